//--- rtl/sfm_pkg.sv
// package: register map, reset values and encodings for the feedforward / mode switch block
`default_nettype none
package sfm_pkg;
  localparam logic [15:0] SFM_OFF_FF_GAIN   = 16'h2109;
  localparam logic [15:0] SFM_OFF_FF_TC     = 16'h210A;
  localparam logic [15:0] SFM_OFF_MS_SEL    = 16'h210B;
  localparam logic [15:0] SFM_OFF_TRQ_LVL   = 16'h210C;
  localparam logic [15:0] SFM_OFF_SPD_ROT   = 16'h210D;
  localparam logic [15:0] SFM_OFF_ACC_ROT   = 16'h210E;
  localparam logic [15:0] SFM_OFF_DEV_LVL   = 16'h210F;
  localparam logic [15:0] SFM_OFF_SPD_LIN   = 16'h2181;
  localparam logic [15:0] SFM_OFF_ACC_LIN   = 16'h2182;
  localparam logic [15:0] SFM_OFF_STATUS    = 16'h2190;

  localparam logic [15:0] SFM_RST_FF_GAIN   = 16'h0000;
  localparam logic [15:0] SFM_RST_FF_TC     = 16'h0000;
  localparam logic [15:0] SFM_RST_MS_SEL    = 16'h0000;
  localparam logic [15:0] SFM_RST_TRQ_LVL   = 16'h00C8;
  localparam logic [15:0] SFM_RST_LVL       = 16'h0000;

  localparam logic [15:0] SFM_MAX_FF_GAIN   = 16'h0064;
  localparam logic [15:0] SFM_MAX_FF_TC     = 16'h1900;
  localparam logic [15:0] SFM_MAX_TRQ_LVL   = 16'h0320;
  localparam logic [15:0] SFM_MAX_SPD_LVL   = 16'h2710;
  localparam logic [15:0] SFM_MAX_ACC_LVL   = 16'h7530;
  localparam logic [15:0] SFM_MAX_DEV_LVL   = 16'h2710;

  localparam int SFM_SEL_LSB = 0;
  localparam int SFM_SEL_W   = 4;
  localparam int SFM_GAIN_DIV = 100;

  typedef enum logic [2:0] {
    SFM_COND_TORQUE = 3'b000,
    SFM_COND_SPEED  = 3'b001,
    SFM_COND_ACCEL  = 3'b010,
    SFM_COND_DEV    = 3'b011,
    SFM_COND_NONE   = 3'b100
  } sfm_cond_t;
endpackage
`default_nettype wire

//--- rtl/sfm_ff_if.sv
// interface: feedforward term in, filtered term out, with settings
`default_nettype none
interface sfm_ff_if;
  logic               step;
  logic signed [31:0] ff_in;
  logic        [15:0] tc;
  logic signed [31:0] ff_out;
  modport core (input step, input ff_in, input tc, output ff_out);
  modport user (output step, output ff_in, output tc, input ff_out);
endinterface
`default_nettype wire

//--- rtl/sfm_lag_filter.sv
// first-order lag on the feedforward term, one update per control cycle step
`default_nettype none
module sfm_lag_filter
  import sfm_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // filter link
  sfm_ff_if.core   ff
);
  logic signed [31:0] acc_r;
  logic signed [47:0] diff_nxt;
  logic signed [47:0] step_nxt;

  // y += (x - y) / (tc + 1): tc in 0.01 ms per control step
  always_comb begin
    diff_nxt = 48'(ff.ff_in) - 48'(acc_r);
    step_nxt = diff_nxt / $signed({32'h0, ff.tc} + 48'h1);
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      acc_r <= 32'sh0;
    end else if (ff.step) begin
      if (ff.tc == 16'h0000) begin
        acc_r <= ff.ff_in;
      end else begin
        acc_r <= 32'(48'(acc_r) + step_nxt);
      end
    end
  end

  assign ff.ff_out = acc_r;

  chk_bypass_zero_tc: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (ff.step && ff.tc == 16'h0000) |=> acc_r == $past(ff.ff_in))
    else $error("zero time constant did not pass term through");
endmodule
`default_nettype wire

//--- rtl/sfm_top.sv
// top: parameter registers, feedforward scaling and P/PI mode switching
//
// The implementer's own choice: strobed register access.
`default_nettype none
// Function
// - Position feedforward is scaled by a gain of 0 to 100 percent, reset 0.
// - The feedforward term is filtered with a 0 to 6400 x 0.01 ms time constant, reset 0.
// - The select low digit picks torque, speed, accel, deviation or none, taking effect at once.
// - After reset the select chooses the torque condition.
// - Torque reference at or above its 0 to 800 percent level forces P-only control.
// - The torque level resets to 200 percent.
// - Rotary speed reference at or above its level forces P-only control.
// - Linear speed reference at or above its level forces P-only control.
// - Rotary acceleration at or above its level forces P-only control.
// - Linear acceleration at or above its level forces P-only control.
// - Position deviation at or above its level forces P-only control.
// - The deviation condition applies only in position control.
module sfm_top
  import sfm_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  // register port
  input  wire logic [15:0] reg_addr_i,
  input  wire logic [15:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output var  logic [15:0] reg_rdata_o,
  // control loop quantities, one sample per control cycle
  input  wire logic        cycle_i,
  input  wire logic        linear_motor_i,
  input  wire logic        pos_ctrl_i,
  input  wire logic [15:0] torque_ref_i,
  input  wire logic [15:0] speed_ref_i,
  input  wire logic [15:0] accel_i,
  input  wire logic [31:0] pos_dev_i,
  input  wire logic signed [31:0] ff_in_i,
  // results
  output var  logic        p_only_o,
  output var  logic signed [31:0] ff_out_o
);
  logic [15:0] ff_gain_r;
  logic [15:0] ff_tc_r;
  logic [15:0] ms_sel_r;
  logic [15:0] trq_lvl_r;
  logic [15:0] spd_rot_r;
  logic [15:0] acc_rot_r;
  logic [15:0] dev_lvl_r;
  logic [15:0] spd_lin_r;
  logic [15:0] acc_lin_r;
  logic        p_only_nxt;
  logic signed [31:0] scaled_nxt;
  logic signed [47:0] prod_nxt;
  logic        step_r;
  logic signed [31:0] scaled_r;
  sfm_cond_t   cond;

  // out-of-range writes clamp to the top of the range
  function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] mx);
    clamp = (v > mx) ? mx : v;
  endfunction

  function automatic sfm_cond_t decode_sel(input logic [15:0] s);
    logic [3:0] d;
    d = s[SFM_SEL_LSB +: SFM_SEL_W];
    unique case (d)
      4'h0:    decode_sel = SFM_COND_TORQUE;
      4'h1:    decode_sel = SFM_COND_SPEED;
      4'h2:    decode_sel = SFM_COND_ACCEL;
      4'h3:    decode_sel = SFM_COND_DEV;
      default: decode_sel = SFM_COND_NONE;
    endcase
  endfunction

  // register writes
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ff_gain_r <= SFM_RST_FF_GAIN;
      ff_tc_r   <= SFM_RST_FF_TC;
      ms_sel_r  <= SFM_RST_MS_SEL;
      trq_lvl_r <= SFM_RST_TRQ_LVL;
      spd_rot_r <= SFM_RST_LVL;
      acc_rot_r <= SFM_RST_LVL;
      dev_lvl_r <= SFM_RST_LVL;
      spd_lin_r <= SFM_RST_LVL;
      acc_lin_r <= SFM_RST_LVL;
    end else if (reg_wr_i) begin
      unique case (reg_addr_i)
        SFM_OFF_FF_GAIN: ff_gain_r <= clamp(reg_wdata_i, SFM_MAX_FF_GAIN);
        SFM_OFF_FF_TC:   ff_tc_r   <= clamp(reg_wdata_i, SFM_MAX_FF_TC);
        SFM_OFF_MS_SEL:  ms_sel_r  <= reg_wdata_i;
        SFM_OFF_TRQ_LVL: trq_lvl_r <= clamp(reg_wdata_i, SFM_MAX_TRQ_LVL);
        SFM_OFF_SPD_ROT: spd_rot_r <= clamp(reg_wdata_i, SFM_MAX_SPD_LVL);
        SFM_OFF_ACC_ROT: acc_rot_r <= clamp(reg_wdata_i, SFM_MAX_ACC_LVL);
        SFM_OFF_DEV_LVL: dev_lvl_r <= clamp(reg_wdata_i, SFM_MAX_DEV_LVL);
        SFM_OFF_SPD_LIN: spd_lin_r <= clamp(reg_wdata_i, SFM_MAX_SPD_LVL);
        SFM_OFF_ACC_LIN: acc_lin_r <= clamp(reg_wdata_i, SFM_MAX_ACC_LVL);
        default: ;
      endcase
    end
  end

  // register reads, data one cycle after the strobe; unmapped reads zero
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= 16'h0000;
    end else if (reg_rd_i) begin
      unique case (reg_addr_i)
        SFM_OFF_FF_GAIN: reg_rdata_o <= ff_gain_r;
        SFM_OFF_FF_TC:   reg_rdata_o <= ff_tc_r;
        SFM_OFF_MS_SEL:  reg_rdata_o <= ms_sel_r;
        SFM_OFF_TRQ_LVL: reg_rdata_o <= trq_lvl_r;
        SFM_OFF_SPD_ROT: reg_rdata_o <= spd_rot_r;
        SFM_OFF_ACC_ROT: reg_rdata_o <= acc_rot_r;
        SFM_OFF_DEV_LVL: reg_rdata_o <= dev_lvl_r;
        SFM_OFF_SPD_LIN: reg_rdata_o <= spd_lin_r;
        SFM_OFF_ACC_LIN: reg_rdata_o <= acc_lin_r;
        SFM_OFF_STATUS:  reg_rdata_o <= {13'h0000, cond};
        default:         reg_rdata_o <= 16'h0000;
      endcase
    end else begin
      reg_rdata_o <= 16'h0000;
    end
  end

  // select decodes combinationally so a new digit acts on the next cycle
  assign cond = decode_sel(ms_sel_r);

  always_comb begin
    p_only_nxt = 1'b0;
    unique case (cond)
      SFM_COND_TORQUE: p_only_nxt = (torque_ref_i >= trq_lvl_r);
      SFM_COND_SPEED:  p_only_nxt = linear_motor_i ? (speed_ref_i >= spd_lin_r)
                                                   : (speed_ref_i >= spd_rot_r);
      SFM_COND_ACCEL:  p_only_nxt = linear_motor_i ? (accel_i >= acc_lin_r)
                                                   : (accel_i >= acc_rot_r);
      SFM_COND_DEV:    p_only_nxt = pos_ctrl_i && (pos_dev_i >= {16'h0000, dev_lvl_r});
      SFM_COND_NONE:   p_only_nxt = 1'b0;
    endcase
  end

  // evaluated at every control cycle, held between
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      p_only_o <= 1'b0;
    end else if (cycle_i) begin
      p_only_o <= p_only_nxt;
    end
  end

  // gain percent; register writes clamp it to 100 or below
  always_comb begin
    prod_nxt   = 48'(ff_in_i) * $signed({32'h0, ff_gain_r});
    scaled_nxt = 32'(prod_nxt / 48'sd100);
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      scaled_r <= 32'sh0;
      step_r   <= 1'b0;
    end else begin
      scaled_r <= scaled_nxt;
      step_r   <= cycle_i;
    end
  end

  sfm_ff_if ffl ();
  assign ffl.step  = step_r;
  assign ffl.ff_in = scaled_r;
  assign ffl.tc    = ff_tc_r;

  sfm_lag_filter u_filt (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .ff        (ffl)
  );

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ff_out_o <= 32'sh0;
    end else begin
      ff_out_o <= ffl.ff_out;
    end
  end

  chk_torque_switch: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (cycle_i && cond == SFM_COND_TORQUE) |=> p_only_o == ($past(torque_ref_i) >= $past(trq_lvl_r)))
    else $error("torque switch decision wrong");
  chk_speed_rotary: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (cycle_i && cond == SFM_COND_SPEED && !linear_motor_i && speed_ref_i >= spd_rot_r)
      |=> p_only_o)
    else $error("rotary speed switch missed");
  chk_speed_linear: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (cycle_i && cond == SFM_COND_SPEED && linear_motor_i && speed_ref_i < spd_lin_r)
      |=> !p_only_o)
    else $error("linear speed switch wrong");
  chk_accel_rotary: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (cycle_i && cond == SFM_COND_ACCEL && !linear_motor_i && accel_i >= acc_rot_r)
      |=> p_only_o)
    else $error("rotary accel switch missed");
  chk_accel_linear: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (cycle_i && cond == SFM_COND_ACCEL && linear_motor_i && accel_i >= acc_lin_r)
      |=> p_only_o)
    else $error("linear accel switch missed");
  chk_dev_posctrl: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (cycle_i && cond == SFM_COND_DEV && !pos_ctrl_i) |=> !p_only_o)
    else $error("deviation switch outside position control");
  chk_dev_switch: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (cycle_i && cond == SFM_COND_DEV && pos_ctrl_i && pos_dev_i >= {16'h0000, dev_lvl_r})
      |=> p_only_o)
    else $error("deviation switch missed");
  chk_none_pi: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (cycle_i && cond == SFM_COND_NONE) |=> !p_only_o)
    else $error("switching disabled but P-only");
  chk_gain_range: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    ff_gain_r <= SFM_MAX_FF_GAIN && ff_tc_r <= SFM_MAX_FF_TC)
    else $error("feedforward setting out of range");
  chk_sel_immediate: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (reg_wr_i && reg_addr_i == SFM_OFF_MS_SEL) |=> ms_sel_r == $past(reg_wdata_i))
    else $error("select write did not land");

  cov_torque_p:  cover property (@(posedge ref_clk_i) disable iff (rst_i)
    cond == SFM_COND_TORQUE && p_only_o);
  cov_dev_p:     cover property (@(posedge ref_clk_i) disable iff (rst_i)
    cond == SFM_COND_DEV && p_only_o);
  cov_p_to_pi:   cover property (@(posedge ref_clk_i) disable iff (rst_i)
    p_only_o ##1 !p_only_o);
  cov_filtered:  cover property (@(posedge ref_clk_i) disable iff (rst_i)
    step_r && ff_tc_r != 16'h0000 && ff_gain_r != 16'h0000);
endmodule
`default_nettype wire

//--- testbench/testbench.sv
// self-checking bench for the feedforward / mode switch block
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import sfm_pkg::*;

  logic               ref_clk_i = 1'b0;
  logic               rst_i = 1'b1;
  logic        [15:0] reg_addr_i = 16'h0000;
  logic        [15:0] reg_wdata_i = 16'h0000;
  logic               reg_wr_i = 1'b0;
  logic               reg_rd_i = 1'b0;
  logic        [15:0] reg_rdata_o;
  logic               cycle_i = 1'b0;
  logic               linear_motor_i = 1'b0;
  logic               pos_ctrl_i = 1'b0;
  logic        [15:0] torque_ref_i = 16'h0000;
  logic        [15:0] speed_ref_i = 16'h0000;
  logic        [15:0] accel_i = 16'h0000;
  logic        [31:0] pos_dev_i = 32'h0000_0000;
  logic signed [31:0] ff_in_i = 32'sh0;
  logic               p_only_o;
  logic signed [31:0] ff_out_o;
  int                 n_mismatch = 0;
  int                 check_count = 0;
  logic        [15:0] offs [9];
  logic        [15:0] dflt [9];

  sfm_top sfm_top_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .cycle_i(cycle_i), .linear_motor_i(linear_motor_i),
    .pos_ctrl_i(pos_ctrl_i), .torque_ref_i(torque_ref_i), .speed_ref_i(speed_ref_i),
    .accel_i(accel_i), .pos_dev_i(pos_dev_i), .ff_in_i(ff_in_i), .p_only_o(p_only_o),
    .ff_out_o(ff_out_o));

  always #25 ref_clk_i = ~ref_clk_i;

  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic do_reset(input int n);
    @(posedge ref_clk_i);
    rst_i <= 1'b1;
    repeat (n) @(posedge ref_clk_i);
    rst_i <= 1'b0;
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge ref_clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge ref_clk_i);
    reg_wr_i    <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge ref_clk_i);
    reg_rd_i   <= 1'b0;
    #1 d = reg_rdata_o;
  endtask

  // one control cycle with the given quantities, result seen two edges later
  task automatic ctl(input logic [15:0] t, input logic [15:0] s, input logic [15:0] ac,
                     input logic [31:0] dv, input logic lin, input logic pc,
                     output logic p);
    @(posedge ref_clk_i);
    torque_ref_i   <= t;
    speed_ref_i    <= s;
    accel_i        <= ac;
    pos_dev_i      <= dv;
    linear_motor_i <= lin;
    pos_ctrl_i     <= pc;
    cycle_i        <= 1'b1;
    @(posedge ref_clk_i);
    cycle_i        <= 1'b0;
    @(posedge ref_clk_i);
    #1 p = p_only_o;
  endtask

  task automatic ff(input logic [31:0] x, output logic [31:0] y);
    @(posedge ref_clk_i);
    ff_in_i <= x;
    repeat (3) @(posedge ref_clk_i);
    cycle_i <= 1'b1;
    @(posedge ref_clk_i);
    cycle_i <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
    #1 y = ff_out_o;
  endtask

  // a hang anywhere ends the run as a failure
  initial begin
    repeat (50000) @(posedge ref_clk_i);
    n_mismatch++;
    end_sim();
  end

  initial begin
    logic [15:0] d;
    logic        p;
    logic [31:0] y;
    offs = '{SFM_OFF_FF_GAIN, SFM_OFF_FF_TC, SFM_OFF_MS_SEL, SFM_OFF_TRQ_LVL, SFM_OFF_SPD_ROT,
             SFM_OFF_ACC_ROT, SFM_OFF_DEV_LVL, SFM_OFF_SPD_LIN, SFM_OFF_ACC_LIN};
    dflt = '{SFM_RST_FF_GAIN, SFM_RST_FF_TC, SFM_RST_MS_SEL, SFM_RST_TRQ_LVL, SFM_RST_LVL,
             SFM_RST_LVL, SFM_RST_LVL, SFM_RST_LVL, SFM_RST_LVL};
    do_reset(10);
    for (int i = 0; i < 9; i++) begin
      rd(offs[i], d);
      chk({16'h0000, d}, {16'h0000, dflt[i]});
    end
    rd(16'h2100, d);
    chk({16'h0000, d}, 32'h0000_0000);
    // torque condition straight after reset, boundary at 200 percent
    ctl(16'h00C8, 16'h0000, 16'h0000, 32'h0, 1'b0, 1'b0, p); chk({31'h0, p}, 32'h1);
    ctl(16'h00C7, 16'h0000, 16'h0000, 32'h0, 1'b0, 1'b0, p); chk({31'h0, p}, 32'h0);
    wr(SFM_OFF_MS_SEL, 16'h0001);
    wr(SFM_OFF_SPD_ROT, 16'h0064);
    wr(SFM_OFF_SPD_LIN, 16'h00C8);
    ctl(16'h0320, 16'h0063, 16'h0000, 32'h0, 1'b0, 1'b0, p); chk({31'h0, p}, 32'h0);
    ctl(16'h0000, 16'h0064, 16'h0000, 32'h0, 1'b0, 1'b0, p); chk({31'h0, p}, 32'h1);
    ctl(16'h0000, 16'h0064, 16'h0000, 32'h0, 1'b1, 1'b0, p); chk({31'h0, p}, 32'h0);
    ctl(16'h0000, 16'h00C8, 16'h0000, 32'h0, 1'b1, 1'b0, p); chk({31'h0, p}, 32'h1);
    wr(SFM_OFF_MS_SEL, 16'h0002);
    wr(SFM_OFF_ACC_ROT, 16'h012C);
    wr(SFM_OFF_ACC_LIN, 16'h03E8);
    ctl(16'h0000, 16'h2710, 16'h012B, 32'h0, 1'b0, 1'b0, p); chk({31'h0, p}, 32'h0);
    ctl(16'h0000, 16'h0000, 16'h012C, 32'h0, 1'b0, 1'b0, p); chk({31'h0, p}, 32'h1);
    ctl(16'h0000, 16'h0000, 16'h03E7, 32'h0, 1'b1, 1'b0, p); chk({31'h0, p}, 32'h0);
    ctl(16'h0000, 16'h0000, 16'h03E8, 32'h0, 1'b1, 1'b0, p); chk({31'h0, p}, 32'h1);
    wr(SFM_OFF_MS_SEL, 16'h0003);
    wr(SFM_OFF_DEV_LVL, 16'h01F4);
    ctl(16'h0000, 16'h0000, 16'h0000, 32'h1F4, 1'b0, 1'b1, p); chk({31'h0, p}, 32'h1);
    ctl(16'h0000, 16'h0000, 16'h0000, 32'h1F4, 1'b0, 1'b0, p); chk({31'h0, p}, 32'h0);
    ctl(16'h0000, 16'h0000, 16'h0000, 32'h1F3, 1'b0, 1'b1, p); chk({31'h0, p}, 32'h0);
    wr(SFM_OFF_MS_SEL, 16'h0004);
    ctl(16'h0320, 16'h2710, 16'h7530, 32'h2710, 1'b0, 1'b1, p); chk({31'h0, p}, 32'h0);
    rd(SFM_OFF_STATUS, d);
    chk({16'h0000, d}, 32'h0000_0004);
    // half gain with no filtering, truncation toward zero on the negative side
    wr(SFM_OFF_FF_GAIN, 16'h0032);
    rd(SFM_OFF_FF_GAIN, d);
    chk({16'h0000, d}, 32'h0000_0032);
    ff(32'sh3E8, y); chk(y, 32'sh1F4);
    ff(-32'sh3E9, y); chk(y, -32'sh1F4);
    // lag filter from a cleared state halves the gap each control cycle
    do_reset(2);
    wr(SFM_OFF_FF_GAIN, 16'h0050);
    wr(SFM_OFF_FF_TC, 16'h0001);
    ff(32'sh3E8, y); chk(y, 32'sh190);
    ff(32'sh3E8, y); chk(y, 32'sh258);
    end_sim();
  end
endmodule
`default_nettype wire
